// *** cpu_flow_map.svh ***
// Register offsets, field positions, opcodes and T-state counts
`ifndef CPU_FLOW_MAP_SVH
`define CPU_FLOW_MAP_SVH

`define OFS_CTRL     8'h00
`define OFS_STATUS   8'h04
`define OFS_PC       8'h08
`define OFS_SP       8'h0c
`define OFS_HL       8'h10
`define OFS_BC       8'h14
`define OFS_FLAGS    8'h18
`define OFS_IX       8'h1c
`define OFS_IY       8'h20

`define CTRL_RUN     0
`define FLAG_S       7
`define FLAG_Z       6
`define FLAG_P       2
`define FLAG_N       1
`define FLAG_C       0

`define RST_WORD     16'h0000
`define RST_FLAGS    8'h00
`define RST_MODE     2'h0

`define OP_NOP       8'h00
`define OP_HALT      8'h76
`define OP_DI        8'hf3
`define OP_EI        8'hfb
`define OP_JP        8'hc3
`define OP_JP_IND    8'he9
`define OP_JR        8'h18
`define OP_DECREMENT_BRANCH_NONZERO      8'h10
`define OP_CALL      8'hcd
`define OP_RET       8'hc9
`define OP_PFX_ED    8'hed
`define OP_PFX_DD    8'hdd
`define OP_PFX_FD    8'hfd
`define OP_IM0       8'h46
`define OP_IM1       8'h56
`define OP_IM2       8'h5e
`define OP_INTERRUPT_RETURN      8'h4d
`define OP_BLOCK_INPUT_INCREMENT_REPEAT      8'hba
`define OP_BLOCK_OUTPUT_INCREMENT_REPEAT      8'hb3
`define OP_BLOCK_INPUT_DECREMENT_REPEAT      8'hb2
`define OP_BLOCK_OUTPUT_DECREMENT_REPEAT      8'hbb

`define T_FETCH      3'd4
`define T_MEM        3'd3
`define T_CALL_HI    3'd4
`define T_EXTRA      3'd1
`define T_IO_STEP    3'd4
`define T_INTERNAL   3'd5
`define T_IDLE       3'd1

`endif

// *** cpu_flow_pkg.sv ***
// Types of the flow core: its state and prefix encodings
`default_nettype none
package cpu_flow_pkg;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,
        S_FETCH  = 4'b0001,
        S_FETCH2 = 4'b0010,
        S_EXTRA  = 4'b0011,
        S_OPLO   = 4'b0100,
        S_OPHI   = 4'b0101,
        S_DISP   = 4'b0110,
        S_RELJ   = 4'b0111,
        S_PUSHH  = 4'b1000,
        S_PUSHL  = 4'b1001,
        S_POPL   = 4'b1010,
        S_POPH   = 4'b1011,
        S_XFER1  = 4'b1100,
        S_XFER2  = 4'b1101,
        S_RPT    = 4'b1110,
        S_HALT   = 4'b1111
    } state_t;

    typedef enum logic [1:0] {
        PFX_NONE = 2'b00,
        PFX_ED   = 2'b01,
        PFX_DD   = 2'b10,
        PFX_FD   = 2'b11
    } pfx_t;

endpackage : cpu_flow_pkg
`default_nettype wire

// *** mcycle_if.sv ***
// Machine-cycle length request and T-state progress
`default_nettype none
interface mcycle_if;
    logic [2:0] len;
    logic [2:0] tstate;
    logic       last;
    modport seq   (output len, input tstate, input last);
    modport timer (input len, output tstate, output last);
endinterface : mcycle_if
`default_nettype wire

// *** mcycle_timer.sv ***
// T-state counter that closes each machine cycle
`default_nettype none
module mcycle_timer (
    input wire logic  pclk,
    input wire logic  presetn,
    input wire logic  ce,
    mcycle_if.timer   mc
);
    logic [2:0] cnt_q;

    assign mc.tstate = cnt_q;
    assign mc.last   = (cnt_q + 3'd1) >= mc.len;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 3'd0;
        else if (ce)
            cnt_q <= mc.last ? 3'd0 : cnt_q + 3'd1;
    end
endmodule : mcycle_timer
`default_nettype wire

// *** cpu_flow_core.sv ***
// Flow-control, CPU-control and repeating block I/O execution core
//
// Local design decisions: the placing of the registers and the APB register port.
`include "cpu_flow_map.svh"
`default_nettype none

// Notes on behaviour
// - Block input/output moves port and memory bytes
// - Counter tested after decrement; zero gives 256
// - Repeat step 21 T, last step 16 T
// - Interrupt check and two refreshes between steps
// - Decrementing input, second byte b2
// - Decrementing output, second byte bb
// - Opcode 00 is no-operation, 4 T
// - Halt repeats dummy fetches until interrupt/reset
// - Disable clears enable flag, 4 T
// - Enable sets both; blocks through next instruction
// - Mode select ed 46/56/5e, 8 T
// - Jump c3, low then high byte, 10 T
// - Jump e9 via pointer 4 T, index 8 T
// - Conditional jump cc 010, 10 T always
// - Relative jump adds encoded displacement, 12 T
// - Short conditional relative jump, 12 or 7 T
// - Decrement counter, branch if nonzero, 13/8 T
// - Call pushes high then low, 17 T
// - Conditional call cc 100, else 10 T
// - Return pops low then high, 10 T
// - Conditional return 11 T taken, 5 T otherwise
// - Interrupt return ed 4d, 14 T
module cpu_flow_core
    import cpu_flow_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    output var  logic [15:0] bus_addr,
    output var  logic [7:0]  bus_wdata,
    input  wire logic [7:0]  bus_rdata,
    output var  logic        mem_rd,
    output var  logic        mem_wr,
    output var  logic        io_rd,
    output var  logic        io_wr,
    output var  logic        opcode_fetch,
    output var  logic        refresh,
    input  wire logic        int_req,
    output var  logic        irq_accept,
    output var  logic        halted
);
    state_t      state_q, state_d;
    pfx_t        pfx_q, pfx_d;
    logic [7:0]  op_q, op_d;
    logic [15:0] tmp_q, tmp_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] hl_q, hl_d;
    logic [15:0] bc_q, bc_d;
    logic [15:0] ix_q, iy_q;
    logic [7:0]  fl_q, fl_d;
    logic        irq_enable_flag_q, irq_enable_flag_d;
    logic        irq_enable_shadow_q, irq_enable_shadow_d;
    logic        eib_q, eib_d;
    logic [1:0]  im_q, im_d;
    logic        run_q;
    logic        irq_take;
    logic        adv;
    logic        blk_in;
    logic        blk_dec;
    logic        call_go;
    logic [7:0]  b_next;
    logic        sw_wr;
    logic        acc;
    logic        fetching;

    mcycle_if mc ();

    mcycle_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .mc      (mc.timer)
    );

    function automatic logic cond_true(input logic [2:0] f,
                                       input logic [7:0] fl);
        logic bit_v;
        unique case (f[2:1])
            2'b00: bit_v = fl[`FLAG_Z];
            2'b01: bit_v = fl[`FLAG_C];
            2'b10: bit_v = fl[`FLAG_P];
            2'b11: bit_v = fl[`FLAG_S];
        endcase
        cond_true = bit_v ~^ f[0];
    endfunction : cond_true

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == `OFS_CTRL || a == `OFS_STATUS || a == `OFS_PC
              || a == `OFS_SP || a == `OFS_HL || a == `OFS_BC
              || a == `OFS_FLAGS || a == `OFS_IX || a == `OFS_IY;
    endfunction : mapped

    assign adv      = ce && mc.last;
    assign blk_in   = op_q == `OP_BLOCK_INPUT_DECREMENT_REPEAT || op_q == `OP_BLOCK_INPUT_INCREMENT_REPEAT;
    assign blk_dec  = op_q == `OP_BLOCK_INPUT_DECREMENT_REPEAT || op_q == `OP_BLOCK_OUTPUT_DECREMENT_REPEAT;
    assign b_next   = bc_q[15:8] - 8'd1;
    assign fetching = state_q == S_FETCH || state_q == S_FETCH2
                   || state_q == S_HALT;
    // Taken call stretches the high operand read by one T state
    assign call_go  = op_q == `OP_CALL
                   || (op_q[7:6] == 2'b11 && op_q[2:0] == 3'b100
                       && cond_true(op_q[5:3], fl_q));

    always_comb
    begin
        unique case (state_q)
            S_IDLE:   mc.len = `T_IDLE;
            S_FETCH, S_FETCH2, S_HALT:
                      mc.len = `T_FETCH;
            S_EXTRA:  mc.len = `T_EXTRA;
            S_OPHI:   mc.len = call_go ? `T_CALL_HI : `T_MEM;
            S_RELJ, S_RPT:
                      mc.len = `T_INTERNAL;
            S_XFER2:  mc.len = `T_IO_STEP;
            S_OPLO, S_DISP, S_PUSHH, S_PUSHL, S_POPL, S_POPH, S_XFER1:
                      mc.len = `T_MEM;
        endcase
    end

    always_comb
    begin
        state_d  = state_q;
        pfx_d    = pfx_q;
        op_d     = op_q;
        tmp_d    = tmp_q;
        pc_d     = pc_q;
        sp_d     = sp_q;
        hl_d     = hl_q;
        bc_d     = bc_q;
        fl_d     = fl_q;
        irq_enable_flag_d   = irq_enable_flag_q;
        irq_enable_shadow_d   = irq_enable_shadow_q;
        eib_d    = eib_q;
        im_d     = im_q;
        irq_take = 1'b0;
        unique case (state_q)
            S_IDLE:
                if (run_q)
                    state_d = S_FETCH;
            S_FETCH, S_HALT:
            begin
                // Recognition point at every instruction boundary
                if (int_req && irq_enable_flag_q && !eib_q)
                begin
                    irq_take = 1'b1;
                    irq_enable_flag_d   = 1'b0;
                    irq_enable_shadow_d   = 1'b0;
                    state_d  = S_FETCH;
                end
                else if (state_q == S_HALT)
                    state_d = S_HALT;
                else if (!run_q)
                    state_d = S_IDLE;
                else
                begin
                    op_d  = bus_rdata;
                    pc_d  = pc_q + 16'd1;
                    pfx_d = PFX_NONE;
                    eib_d = bus_rdata == `OP_EI;
                    state_d = S_FETCH;
                    if (bus_rdata == `OP_HALT)
                        state_d = S_HALT;
                    else if (bus_rdata == `OP_DI)
                        irq_enable_flag_d = 1'b0;
                    else if (bus_rdata == `OP_EI)
                    begin
                        irq_enable_flag_d = 1'b1;
                        irq_enable_shadow_d = 1'b1;
                    end
                    else if (bus_rdata == `OP_JP_IND)
                        pc_d = hl_q;
                    else if (bus_rdata == `OP_JR
                             || (bus_rdata[7:5] == 3'b001
                                 && bus_rdata[2:0] == 3'b000))
                        state_d = S_DISP;
                    else if (bus_rdata == `OP_DECREMENT_BRANCH_NONZERO)
                    begin
                        bc_d[15:8] = bc_q[15:8] - 8'd1;
                        state_d = S_EXTRA;
                    end
                    else if (bus_rdata == `OP_RET)
                        state_d = S_POPL;
                    else if (bus_rdata[7:6] == 2'b11
                             && bus_rdata[2:0] == 3'b000)
                        state_d = S_EXTRA;
                    else if (bus_rdata == `OP_JP || bus_rdata == `OP_CALL
                             || (bus_rdata[7:6] == 2'b11
                                 && (bus_rdata[2:0] == 3'b010
                                     || bus_rdata[2:0] == 3'b100)))
                        state_d = S_OPLO;
                    else if (bus_rdata == `OP_PFX_ED)
                    begin
                        pfx_d = PFX_ED;
                        state_d = S_FETCH2;
                    end
                    else if (bus_rdata == `OP_PFX_DD
                             || bus_rdata == `OP_PFX_FD)
                    begin
                        pfx_d = bus_rdata == `OP_PFX_DD ? PFX_DD : PFX_FD;
                        state_d = S_FETCH2;
                    end
                end
            end
            S_FETCH2:
            begin
                op_d = bus_rdata;
                pc_d = pc_q + 16'd1;
                state_d = S_FETCH;
                if (pfx_q == PFX_ED)
                begin
                    if (bus_rdata == `OP_IM0)
                        im_d = 2'd0;
                    else if (bus_rdata == `OP_IM1)
                        im_d = 2'd1;
                    else if (bus_rdata == `OP_IM2)
                        im_d = 2'd2;
                    else if (bus_rdata == `OP_INTERRUPT_RETURN)
                        state_d = S_POPL;
                    else if (bus_rdata == `OP_BLOCK_INPUT_INCREMENT_REPEAT
                             || bus_rdata == `OP_BLOCK_OUTPUT_INCREMENT_REPEAT
                             || bus_rdata == `OP_BLOCK_INPUT_DECREMENT_REPEAT
                             || bus_rdata == `OP_BLOCK_OUTPUT_DECREMENT_REPEAT)
                        state_d = S_EXTRA;
                end
                else if (bus_rdata == `OP_JP_IND)
                    pc_d = pfx_q == PFX_DD ? ix_q : iy_q;
            end
            S_EXTRA:
                if (pfx_q == PFX_ED)
                    state_d = S_XFER1;
                else if (op_q == `OP_DECREMENT_BRANCH_NONZERO)
                    state_d = S_DISP;
                else
                    state_d = cond_true(op_q[5:3], fl_q)
                            ? S_POPL : S_FETCH;
            S_OPLO:
            begin
                tmp_d[7:0] = bus_rdata;
                pc_d = pc_q + 16'd1;
                state_d = S_OPHI;
            end
            S_OPHI:
            begin
                tmp_d[15:8] = bus_rdata;
                pc_d = pc_q + 16'd1;
                state_d = S_FETCH;
                if (op_q == `OP_JP || (op_q[2:0] == 3'b010
                                       && cond_true(op_q[5:3], fl_q)))
                    pc_d = {bus_rdata, tmp_q[7:0]};
                else if (call_go)
                    state_d = S_PUSHH;
            end
            S_PUSHH:
            begin
                sp_d = sp_q - 16'd1;
                state_d = S_PUSHL;
            end
            S_PUSHL:
            begin
                sp_d = sp_q - 16'd1;
                pc_d = tmp_q;
                state_d = S_FETCH;
            end
            S_POPL:
            begin
                tmp_d[7:0] = bus_rdata;
                sp_d = sp_q + 16'd1;
                state_d = S_POPH;
            end
            S_POPH:
            begin
                pc_d = {bus_rdata, tmp_q[7:0]};
                sp_d = sp_q + 16'd1;
                state_d = S_FETCH;
            end
            S_DISP:
            begin
                tmp_d[7:0] = bus_rdata;
                pc_d = pc_q + 16'd1;
                if (op_q == `OP_JR)
                    state_d = S_RELJ;
                else if (op_q == `OP_DECREMENT_BRANCH_NONZERO)
                    state_d = bc_q[15:8] != 8'd0
                            ? S_RELJ : S_FETCH;
                else
                    state_d = cond_true({1'b0, op_q[4:3]}, fl_q)
                            ? S_RELJ : S_FETCH;
            end
            S_RELJ:
            begin
                // Displacement is relative to the byte after the operand
                pc_d = pc_q + {{8{tmp_q[7]}}, tmp_q[7:0]};
                state_d = S_FETCH;
            end
            S_XFER1:
            begin
                tmp_d[7:0] = bus_rdata;
                state_d = S_XFER2;
            end
            S_XFER2:
            begin
                hl_d = blk_dec ? hl_q - 16'd1
                               : hl_q + 16'd1;
                bc_d[15:8] = b_next;
                fl_d[`FLAG_Z] = b_next == 8'd0;
                fl_d[`FLAG_N] = 1'b1;
                // Zero is tested after the decrement
                state_d = b_next != 8'd0 ? S_RPT : S_FETCH;
            end
            S_RPT:
            begin
                pc_d = pc_q - 16'd2;
                state_d = S_FETCH;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            pfx_q   <= PFX_NONE;
            op_q    <= `OP_NOP;
            tmp_q   <= `RST_WORD;
            irq_enable_flag_q  <= 1'b0;
            irq_enable_shadow_q  <= 1'b0;
            eib_q   <= 1'b0;
            im_q    <= `RST_MODE;
        end
        else if (adv)
        begin
            state_q <= state_d;
            pfx_q   <= pfx_d;
            op_q    <= op_d;
            tmp_q   <= tmp_d;
            irq_enable_flag_q  <= irq_enable_flag_d;
            irq_enable_shadow_q  <= irq_enable_shadow_d;
            eib_q   <= eib_d;
            im_q    <= im_d;
        end
    end

    // Software may load the register file only while the core is idle
    assign acc     = psel && penable;
    assign sw_wr   = ce && acc && pwrite && !run_q && state_q == S_IDLE;
    assign pready  = 1'b1;
    assign pslverr = acc && (!mapped(paddr) || (pwrite
                     && paddr != `OFS_CTRL
                     && (paddr == `OFS_STATUS || run_q
                         || state_q != S_IDLE)));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_q <= `RST_WORD;
            sp_q <= `RST_WORD;
            hl_q <= `RST_WORD;
            bc_q <= `RST_WORD;
            ix_q <= `RST_WORD;
            iy_q <= `RST_WORD;
            fl_q <= `RST_FLAGS;
        end
        else if (sw_wr)
        begin
            if (paddr == `OFS_PC)
                pc_q <= pwdata[15:0];
            if (paddr == `OFS_SP)
                sp_q <= pwdata[15:0];
            if (paddr == `OFS_HL)
                hl_q <= pwdata[15:0];
            if (paddr == `OFS_BC)
                bc_q <= pwdata[15:0];
            if (paddr == `OFS_IX)
                ix_q <= pwdata[15:0];
            if (paddr == `OFS_IY)
                iy_q <= pwdata[15:0];
            if (paddr == `OFS_FLAGS)
                fl_q <= pwdata[7:0];
        end
        else if (adv)
        begin
            pc_q <= pc_d;
            sp_q <= sp_d;
            hl_q <= hl_d;
            bc_q <= bc_d;
            fl_q <= fl_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q  <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (acc && pwrite && paddr == `OFS_CTRL)
                run_q <= pwdata[`CTRL_RUN];
            if (psel && !penable)
            begin
                unique case (paddr)
                    `OFS_CTRL:   prdata <= {31'h0, run_q};
                    `OFS_STATUS: prdata <= {20'h0, state_q, 2'h0, im_q,
                                            eib_q, irq_enable_shadow_q, irq_enable_flag_q, halted};
                    `OFS_PC:     prdata <= {16'h0, pc_q};
                    `OFS_SP:     prdata <= {16'h0, sp_q};
                    `OFS_HL:     prdata <= {16'h0, hl_q};
                    `OFS_BC:     prdata <= {16'h0, bc_q};
                    `OFS_FLAGS:  prdata <= {24'h0, fl_q};
                    `OFS_IX:     prdata <= {16'h0, ix_q};
                    `OFS_IY:     prdata <= {16'h0, iy_q};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus strobes follow the machine cycle one clock late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_rd       <= 1'b0;
            mem_wr       <= 1'b0;
            io_rd        <= 1'b0;
            io_wr        <= 1'b0;
            opcode_fetch <= 1'b0;
            refresh      <= 1'b0;
            bus_addr     <= `RST_WORD;
            bus_wdata    <= 8'h00;
            irq_accept   <= 1'b0;
            halted       <= 1'b0;
        end
        else if (ce)
        begin
            mem_rd <= fetching || state_q == S_OPLO || state_q == S_OPHI
                   || state_q == S_DISP || state_q == S_POPL
                   || state_q == S_POPH
                   || (state_q == S_XFER1 && !blk_in);
            mem_wr <= state_q == S_PUSHH || state_q == S_PUSHL
                   || (state_q == S_XFER2 && blk_in);
            io_rd  <= state_q == S_XFER1 && blk_in;
            io_wr  <= state_q == S_XFER2 && !blk_in;
            opcode_fetch <= fetching;
            refresh <= (fetching && mc.tstate >= 3'd2)
                    || (state_q == S_RPT && mc.tstate[0]);
            unique case (state_q)
                S_PUSHH, S_PUSHL:
                    bus_addr <= sp_q - 16'd1;
                S_POPL, S_POPH:
                    bus_addr <= sp_q;
                S_XFER1:
                    bus_addr <= blk_in ? bc_q : hl_q;
                S_XFER2:
                    bus_addr <= blk_in ? hl_q : bc_q;
                S_IDLE, S_FETCH, S_FETCH2, S_EXTRA, S_OPLO, S_OPHI,
                S_DISP, S_RELJ, S_RPT, S_HALT:
                    bus_addr <= pc_q;
            endcase
            bus_wdata <= state_q == S_PUSHH ? pc_q[15:8]
                       : state_q == S_PUSHL ? pc_q[7:0] : tmp_q[7:0];
            irq_accept <= adv && irq_take;
            if (adv)
                halted <= state_d == S_HALT;
        end
    end
endmodule : cpu_flow_core
`default_nettype wire

// *** cpu_flow_checker.sv ***
// Bus-side assertions for the flow and block I/O core
`default_nettype none
module cpu_flow_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic opcode_fetch,
    input wire logic refresh,
    input wire logic irq_accept,
    input wire logic halted
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_fetch_read:
    assert property (opcode_fetch |-> mem_rd && !mem_wr) else $error("fetch");
    chk_fetch_len:
    assert property ($rose(opcode_fetch) |-> opcode_fetch[*4]) else $error("f");
    chk_port_len:
    assert property ($rose(io_rd) |-> io_rd[*3] ##1 !io_rd) else $error("io");
    chk_read_store:
    assert property ($fell(io_rd) |-> mem_wr) else $error("store");
    chk_refresh_quiet:
    assert property (refresh |-> !io_rd && !io_wr) else $error("refresh");
    chk_halt_still:
    assert property (halted |-> !mem_wr && !io_wr && !io_rd) else $error("h");
    chk_halt_fetch:
    assert property (halted |-> ##[0:4] opcode_fetch) else $error("dummy");
    chk_accept_pulse:
    assert property (irq_accept |=> !irq_accept) else $error("accept");
    cover property (io_rd ##3 mem_wr);
    cover property ($rose(halted));
    cover property (irq_accept);
endmodule : cpu_flow_checker
bind cpu_flow_core cpu_flow_checker u_chk (.pclk, .presetn, .mem_rd,
    .mem_wr, .io_rd, .io_wr, .opcode_fetch, .refresh, .irq_accept, .halted);
`default_nettype wire

// *** flow_mem_model.sv ***
// Memory and port model on the far side of the core's bus
`default_nettype none
module flow_mem_model (
    input  wire logic        pclk,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        io_rd,
    output var  logic [7:0]  bus_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    // Plain always: the bench preloads the array from outside
    always @(posedge pclk)
    begin
        if (mem_wr)
            mem[bus_addr] <= bus_wdata;
        last_q <= bus_rdata;
    end
    // Port byte follows the port index; an idle bus toggles
    always_comb
    begin
        if (mem_rd)
            bus_rdata = mem[bus_addr];
        else if (io_rd)
            bus_rdata = bus_addr[7:0] ^ 8'h5a;
        else
            bus_rdata = ~last_q;
    end
endmodule : flow_mem_model
`default_nettype wire

// *** cpu_block_io_and_flow_control_test.sv ***
// Bench for the flow and block I/O core
`include "cpu_flow_map.svh"
`default_nettype none
module cpu_block_io_and_flow_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        mem_rd, mem_wr, io_rd, io_wr, opcode_fetch, refresh;
    logic        int_req, irq_accept, halted, err, rq, wq;
    logic [7:0]  paddr, bus_wdata, bus_rdata;
    logic [15:0] bus_addr;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares = 0, n_checks = 0, n_in, n_out, n_acc, gap, t;
    cpu_flow_core dut (.pclk, .presetn, .ce(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_addr,
        .bus_wdata, .bus_rdata, .mem_rd, .mem_wr, .io_rd, .io_wr,
        .opcode_fetch, .refresh, .int_req, .irq_accept, .halted);
    flow_mem_model u_mem (.pclk, .bus_addr, .bus_wdata, .mem_rd, .mem_wr,
        .io_rd, .bus_rdata);
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Counts port strobes, accepts and the spacing of port writes
    always @(posedge pclk)
    begin
        rq <= io_rd;
        wq <= io_wr;
        n_in <= presetn ? n_in + int'(io_rd && !rq) : 0;
        n_out <= presetn ? n_out + int'(io_wr && !wq) : 0;
        n_acc <= presetn ? n_acc + int'(irq_accept) : 0;
        t <= (io_wr && !wq) ? 1 : t + 1;
        if (io_wr && !wq)
            gap <= t;
    end
    task automatic check(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold the request until pready is seen high at a rising edge
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_for(ref logic s, input int lim);
        int k = 0;
        while (s !== 1'b1 && k < lim)
        begin
            @(negedge pclk);
            k++;
        end
        if (k >= lim)
            miscompares++;
    endtask : wait_for
    task automatic load(input logic [15:0] a, input logic [7:0] b[$]);
        foreach (b[i])
            u_mem.mem[a + 16'(i)] = b[i];
    endtask : load
    task automatic start(input logic [7:0] r1, input int v1, v2);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, r1, v1);
        apb(1'b1, `OFS_BC, v2);
    endtask : start
    task automatic block_io();
        load(16'h0000, '{8'hed, 8'hba, 8'hed, 8'hbb, 8'h76});
        start(`OFS_HL, 32'h0080, 32'h0210);
        apb(1'b1, `OFS_CTRL, 32'h1);
        wait_for(halted, 8000);
        check(n_in, 2);
        check(n_out, 256);
        check(gap, 21);
        check(u_mem.mem[16'h0081], 8'h4a);
        apb(1'b0, `OFS_HL, 0);
        check(rd, 32'hff82);
        apb(1'b0, `OFS_BC, 0);
        check(rd, 32'h0010);
        apb(1'b0, 8'h40, 0);
        check(err, 1'b1);
    endtask : block_io
    task automatic flow();
        load(16'h0000, '{8'h00, 8'hf3, 8'hed, 8'h5e, 8'hca, 8'h30, 8'h00,
                         8'hc3, 8'h10, 8'h00});
        load(16'h0010, '{8'hc4, 8'h20, 8'h00, 8'h20, 8'h03, 8'h76, 8'h76,
                         8'h76, 8'h10, 8'hfe, 8'h76});
        load(16'h0020, '{8'hc0});
        load(16'h0030, '{8'h76});
        start(`OFS_SP, 32'h0100, 32'h0300);
        apb(1'b1, `OFS_CTRL, 32'h1);
        wait_for(halted, 2000);
        check(u_mem.mem[16'h00ff], 8'h00);
        check(u_mem.mem[16'h00fe], 8'h13);
        apb(1'b0, `OFS_SP, 0);
        check(rd, 32'h0100);
        apb(1'b0, `OFS_BC, 0);
        check(rd, 32'h0);
        apb(1'b0, `OFS_STATUS, 0);
        check(rd & 32'h32, 32'h20);
    endtask : flow
    task automatic irq();
        load(16'h0000, '{8'hfb, 8'h76, 8'h76});
        start(`OFS_SP, 32'h0100, 32'h0);
        int_req <= 1'b1;
        apb(1'b1, `OFS_CTRL, 32'h1);
        wait_for(halted, 200);
        check(n_acc, 0);
        wait_for(irq_accept, 40);
        int_req <= 1'b0;
        repeat (20) @(posedge pclk);
        check(n_acc, 1);
        apb(1'b0, `OFS_STATUS, 0);
        check(rd & 32'h7, 32'h1);
    endtask : irq
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        {presetn, psel, penable, pwrite, int_req} = '0;
        paddr = '0;
        pwdata = '0;
        block_io();
        flow();
        irq();
        report_and_stop();
    end
    initial
    begin
        #1ms;
        miscompares++;
        report_and_stop();
    end
endmodule : cpu_block_io_and_flow_control_test
`default_nettype wire
